//--- design/power_mode_reset_pkg.sv
`default_nettype none

package power_mode_reset_pkg;

  // ----------------------------------------------------------------------------
  // register map, byte addresses on the register bus
  // ----------------------------------------------------------------------------
  localparam int          ADDR_W              = 5;
  localparam int          DATA_W              = 32;
  localparam logic [4:0]  POWER_CONTROL_OFF   = 5'h00;
  localparam logic [4:0]  OSC_CONTROL_OFF     = 5'h04;
  localparam logic [4:0]  RESET_ENABLE_OFF    = 5'h08;
  localparam logic [4:0]  RESET_CAUSE_OFF     = 5'h0C;
  localparam logic [4:0]  SOFT_RESET_OFF      = 5'h10;
  localparam logic [4:0]  MODE_STATUS_OFF     = 5'h14;
  localparam logic [4:0]  WATCHDOG_CTRL_OFF   = 5'h18;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int          IDLE_BIT            = 0;
  localparam int          STOP_BIT            = 1;
  localparam int          CLK_INTERNAL_BIT    = 4;
  localparam int          SUSPEND_BIT         = 5;
  localparam int          SOFT_RESET_BIT      = 0;
  localparam int          WDOG_ENABLE_BIT     = 0;
  localparam int          WDOG_LOCK_BIT       = 1;

  // ----------------------------------------------------------------------------
  // reset sources, one bit each
  // ----------------------------------------------------------------------------
  localparam int          NUM_SOURCES         = 8;
  localparam int          SRC_POWER_ON        = 0;
  localparam int          SRC_SUPPLY          = 1;
  localparam int          SRC_WATCHDOG        = 2;
  localparam int          SRC_MISSING_CLOCK   = 3;
  localparam int          SRC_COMPARATOR      = 4;
  localparam int          SRC_SOFTWARE        = 5;
  localparam int          SRC_PIN             = 6;
  localparam int          SRC_FLASH           = 7;
  localparam logic [7:0]  ALWAYS_ON_MASK      = 8'hC1;
  localparam logic [7:0]  RESET_ENABLE_RESET  = 8'hFF;
  localparam logic [7:0]  CAUSE_POWER_ON      = 8'h01;
  localparam logic        CLK_INTERNAL_RESET  = 1'b1;
  localparam logic        WDOG_ENABLE_RESET   = 1'b1;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int          CLOCK_PERIOD_NS     = 100;
  localparam int          RESET_HOLD_NS       = 400;
  localparam int          RESET_HOLD_CYCLES   =
    (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_ACTIVE  = 4'b0001,
    MODE_IDLE    = 4'b0010,
    MODE_SUSPEND = 4'b0100,
    MODE_STOP    = 4'b1000
  } power_mode_t;

endpackage : power_mode_reset_pkg

`default_nettype wire

//--- design/reset_source_combiner.sv
`timescale 1ns/1ps
`default_nettype none

module reset_source_combiner #(
  parameter int N = 8
) (
  // sources and masks
  input  wire logic [N-1:0] i_source,
  input  wire logic [N-1:0] i_enable,
  input  wire logic [N-1:0] i_always_on,
  // result
  output logic              o_any,
  output logic [N-1:0]      o_active
);

  // ----------------------------------------------------------------------------
  // per-source gating
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_src
      // locked-on sources ignore the software enable
      assign o_active[g] = i_source[g] & (i_enable[g] | i_always_on[g]);
    end
  endgenerate

  assign o_any = |o_active;

endmodule : reset_source_combiner

`default_nettype wire

//--- design/power_mode_reset_control.sv
// What this block does
// [RULE1] There are exactly four modes, active, idle, suspend and stop, with active the normal one.
// [RULE2] The idle bit halts the CPU while clocks run, and an enabled interrupt or a reset wakes it.
// [RULE3] The suspend bit stops the oscillator; a port 0 or port 1 match or a low comparator wakes it.
// [RULE4] In suspend with the internal oscillator as clock source, CPU and peripherals are stopped.
// [RULE5] Suspend and stop halt the CPU, the interrupt and timer logic and the internal oscillator.
// [RULE6] The stop bit stops the system clock and digital peripherals until a device reset.
// [RULE7] Eight reset sources are combined into one device reset.
// [RULE8] All sources but power-on, the reset pin and flash error can be disabled by software.
// [RULE9] Software can lock the watchdog enabled so that later writes cannot turn it off.
// [RULE10] A debug halt stalls every peripheral except the converter.
// [RULE11] The idle and stop bits clear themselves when their mode is left.
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module power_mode_reset_control #(
  parameter int HOLD_CYCLES = power_mode_reset_pkg::RESET_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // register bus
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // wake-up events and debug halt
  input  wire logic        i_irq_pending,
  input  wire logic        i_port0_match,
  input  wire logic        i_port1_match,
  input  wire logic        i_comparator_enable,
  input  wire logic        i_comparator_out,
  input  wire logic        i_debug_halt,
  // reset sources
  input  wire logic        i_power_on_detect,
  input  wire logic        i_vdd_low,
  input  wire logic        i_watchdog_expired,
  input  wire logic        i_missing_clock,
  input  wire logic        i_comparator_reset,
  input  wire logic        i_pin_reset,
  input  wire logic        i_flash_error,
  // gating and status
  output logic             o_cpu_run,
  output logic             o_system_clock_run,
  output logic             o_periph_run,
  output logic             o_adc_run,
  output logic             o_irq_timer_run,
  output logic             o_internal_osc_run,
  output logic             o_watchdog_enable,
  output logic             o_device_reset,
  output logic      [3:0]  o_mode
);

  // ----------------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------------
  logic rst_sync1;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync1 <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n     <= rst_sync1;
    end
  end

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  power_mode_reset_pkg::power_mode_t mode;
  power_mode_reset_pkg::power_mode_t next_mode;
  power_mode_reset_pkg::power_mode_t eff_mode;
  logic        idle_req;
  logic        stop_req;
  logic        suspend_req;
  logic        clk_internal;
  logic [7:0]  rst_enable;
  logic [7:0]  reset_cause;
  logic        sw_reset;
  logic        wdog_lock;
  logic [2:0]  hold_cnt;
  logic [7:0]  src_vec;
  logic [7:0]  src_active;
  logic        src_any;
  logic        wake;
  logic        wr_en;
  logic        system_clock_net_on;
  logic [31:0] read_mux;

  assign wr_en = i_write && !o_waitrequest && i_byteenable[0];
  assign wake  = i_port0_match | i_port1_match |
                 (i_comparator_enable & ~i_comparator_out);      // [RULE3]

  // ----------------------------------------------------------------------------
  // bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_waitrequest <= 1'b1;
    end else if (o_waitrequest && (i_read || i_write)) begin
      o_waitrequest <= 1'b0;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    case (i_address)
      power_mode_reset_pkg::POWER_CONTROL_OFF: begin
        read_mux[power_mode_reset_pkg::IDLE_BIT] = idle_req;
        read_mux[power_mode_reset_pkg::STOP_BIT] = stop_req;
      end
      power_mode_reset_pkg::OSC_CONTROL_OFF: begin
        read_mux[power_mode_reset_pkg::CLK_INTERNAL_BIT] = clk_internal;
        read_mux[power_mode_reset_pkg::SUSPEND_BIT]      = suspend_req;
      end
      power_mode_reset_pkg::RESET_ENABLE_OFF: read_mux[7:0] = rst_enable;
      power_mode_reset_pkg::RESET_CAUSE_OFF:  read_mux[7:0] = reset_cause;
      power_mode_reset_pkg::MODE_STATUS_OFF:  read_mux[3:0] = mode;
      power_mode_reset_pkg::WATCHDOG_CTRL_OFF: begin
        read_mux[power_mode_reset_pkg::WDOG_ENABLE_BIT] = o_watchdog_enable;
        read_mux[power_mode_reset_pkg::WDOG_LOCK_BIT]   = wdog_lock;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // data captured when the request is first seen, stands until the next read
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (o_waitrequest && i_read) begin
      o_readdata <= read_mux;
    end
  end

  // ----------------------------------------------------------------------------
  // mode request bits
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_req <= 1'b0;
      stop_req <= 1'b0;
    end else if (o_device_reset) begin
      idle_req <= 1'b0;                                          // [RULE2]
      stop_req <= 1'b0;                                          // [RULE11]
    end else if (wr_en && i_address == power_mode_reset_pkg::POWER_CONTROL_OFF) begin
      idle_req <= i_writedata[power_mode_reset_pkg::IDLE_BIT];   // [RULE2]
      stop_req <= i_writedata[power_mode_reset_pkg::STOP_BIT];   // [RULE6]
    end else if (mode == power_mode_reset_pkg::MODE_IDLE &&
                 next_mode != power_mode_reset_pkg::MODE_IDLE) begin
      idle_req <= 1'b0;                                          // [RULE11]
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      suspend_req  <= 1'b0;
      clk_internal <= power_mode_reset_pkg::CLK_INTERNAL_RESET;
    end else if (o_device_reset) begin
      suspend_req  <= 1'b0;
      clk_internal <= power_mode_reset_pkg::CLK_INTERNAL_RESET;
    end else if (wr_en && i_address == power_mode_reset_pkg::OSC_CONTROL_OFF) begin
      suspend_req  <= i_writedata[power_mode_reset_pkg::SUSPEND_BIT];      // [RULE3]
      clk_internal <= i_writedata[power_mode_reset_pkg::CLK_INTERNAL_BIT];
    end else if (mode == power_mode_reset_pkg::MODE_SUSPEND && wake) begin
      suspend_req  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // reset sources and enables
  // ----------------------------------------------------------------------------
  // enables and the lock survive device resets; only power-up clears them
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_enable <= power_mode_reset_pkg::RESET_ENABLE_RESET;
    end else if (wr_en && i_address == power_mode_reset_pkg::RESET_ENABLE_OFF) begin
      rst_enable <= i_writedata[7:0] | power_mode_reset_pkg::ALWAYS_ON_MASK;  // [RULE8]
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= wr_en && !o_device_reset &&
                  i_address == power_mode_reset_pkg::SOFT_RESET_OFF &&
                  i_writedata[power_mode_reset_pkg::SOFT_RESET_BIT];
    end
  end

  always_comb begin
    src_vec = 8'h00;
    src_vec[power_mode_reset_pkg::SRC_POWER_ON]      = i_power_on_detect;
    src_vec[power_mode_reset_pkg::SRC_SUPPLY]        = i_vdd_low;
    src_vec[power_mode_reset_pkg::SRC_WATCHDOG]      = i_watchdog_expired;
    src_vec[power_mode_reset_pkg::SRC_MISSING_CLOCK] = i_missing_clock;
    src_vec[power_mode_reset_pkg::SRC_COMPARATOR]    = i_comparator_reset;
    src_vec[power_mode_reset_pkg::SRC_SOFTWARE]      = sw_reset;
    src_vec[power_mode_reset_pkg::SRC_PIN]           = i_pin_reset;
    src_vec[power_mode_reset_pkg::SRC_FLASH]         = i_flash_error;
  end

  reset_source_combiner #(
    .N (power_mode_reset_pkg::NUM_SOURCES)
  ) u_combiner (
    .i_source    (src_vec),
    .i_enable    (rst_enable),
    .i_always_on (power_mode_reset_pkg::ALWAYS_ON_MASK),
    .o_any       (src_any),
    .o_active    (src_active)
  );                                                             // [RULE7]

  // stretched so the rest of the chip sees a clean minimum width
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_device_reset <= 1'b0;
      hold_cnt       <= 3'd0;
      reset_cause    <= power_mode_reset_pkg::CAUSE_POWER_ON;
    end else if (src_any) begin
      o_device_reset <= 1'b1;                                    // [RULE7]
      hold_cnt       <= 3'(HOLD_CYCLES - 1);
      if (!o_device_reset) begin
        reset_cause <= src_active;
      end
    end else if (hold_cnt != 3'd0) begin
      hold_cnt <= hold_cnt - 3'd1;
    end else begin
      o_device_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // watchdog enable and lock
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_watchdog_enable <= power_mode_reset_pkg::WDOG_ENABLE_RESET;
      wdog_lock         <= 1'b0;
    end else if (o_device_reset) begin
      o_watchdog_enable <= power_mode_reset_pkg::WDOG_ENABLE_RESET;
    end else if (wr_en && i_address == power_mode_reset_pkg::WATCHDOG_CTRL_OFF) begin
      wdog_lock         <= wdog_lock | i_writedata[power_mode_reset_pkg::WDOG_LOCK_BIT];
      o_watchdog_enable <= i_writedata[power_mode_reset_pkg::WDOG_ENABLE_BIT] |
                           i_writedata[power_mode_reset_pkg::WDOG_LOCK_BIT] |
                           wdog_lock;                            // [RULE9]
    end
  end

  // ----------------------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      power_mode_reset_pkg::MODE_ACTIVE: begin
        if (stop_req) begin
          next_mode = power_mode_reset_pkg::MODE_STOP;           // [RULE6]
        end else if (suspend_req) begin
          next_mode = power_mode_reset_pkg::MODE_SUSPEND;        // [RULE3]
        end else if (idle_req) begin
          next_mode = power_mode_reset_pkg::MODE_IDLE;           // [RULE2]
        end
      end
      power_mode_reset_pkg::MODE_IDLE: begin
        if (i_irq_pending) begin
          next_mode = power_mode_reset_pkg::MODE_ACTIVE;         // [RULE2]
        end
      end
      power_mode_reset_pkg::MODE_SUSPEND: begin
        if (wake) begin
          next_mode = power_mode_reset_pkg::MODE_ACTIVE;         // [RULE3]
        end
      end
      power_mode_reset_pkg::MODE_STOP: next_mode = mode;         // [RULE6]
      default: next_mode = power_mode_reset_pkg::MODE_ACTIVE;    // [RULE1]
    endcase
  end

  assign eff_mode  = o_device_reset ? power_mode_reset_pkg::MODE_ACTIVE : next_mode;
  assign system_clock_net_on = eff_mode != power_mode_reset_pkg::MODE_STOP &&
                     !(eff_mode == power_mode_reset_pkg::MODE_SUSPEND && clk_internal);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= power_mode_reset_pkg::MODE_ACTIVE;
    end else begin
      mode <= eff_mode;                                          // [RULE1]
    end
  end

  // ----------------------------------------------------------------------------
  // gating outputs, aligned with the mode register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_cpu_run          <= 1'b1;
      o_system_clock_run <= 1'b1;
      o_periph_run       <= 1'b1;
      o_adc_run          <= 1'b1;
      o_irq_timer_run    <= 1'b1;
      o_internal_osc_run <= 1'b1;
      o_mode             <= power_mode_reset_pkg::MODE_ACTIVE;
    end else begin
      o_cpu_run          <= eff_mode == power_mode_reset_pkg::MODE_ACTIVE;  // [RULE5]
      o_system_clock_run <= system_clock_net_on;                                       // [RULE4]
      // converter keeps sampling through a debug halt
      o_periph_run       <= system_clock_net_on && !i_debug_halt;                      // [RULE10]
      o_adc_run          <= system_clock_net_on;
      o_irq_timer_run    <= eff_mode == power_mode_reset_pkg::MODE_ACTIVE ||
                            eff_mode == power_mode_reset_pkg::MODE_IDLE;     // [RULE5]
      o_internal_osc_run <= eff_mode != power_mode_reset_pkg::MODE_SUSPEND &&
                            eff_mode != power_mode_reset_pkg::MODE_STOP;     // [RULE5]
      o_mode             <= eff_mode;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  property p_one_mode;
    $onehot(mode) && (o_mode == mode);
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode not one-hot"); // [RULE1]

  property p_idle_entry;
    mode == power_mode_reset_pkg::MODE_ACTIVE && idle_req && !stop_req && !suspend_req
      && !o_device_reset && !src_any |=> mode == power_mode_reset_pkg::MODE_IDLE
      && !o_cpu_run && o_system_clock_run && o_irq_timer_run;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong"); // [RULE2]

  property p_idle_exit;
    mode == power_mode_reset_pkg::MODE_IDLE && i_irq_pending
      |=> mode == power_mode_reset_pkg::MODE_ACTIVE && o_cpu_run && !idle_req;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong"); // [RULE11]

  property p_suspend_wake;
    mode == power_mode_reset_pkg::MODE_SUSPEND && wake
      |=> mode == power_mode_reset_pkg::MODE_ACTIVE && o_internal_osc_run;
  endproperty
  a_suspend_wake: assert property (p_suspend_wake) else $error("no wake"); // [RULE3]

  property p_suspend_clock;
    o_mode == power_mode_reset_pkg::MODE_SUSPEND && $past(clk_internal)
      |-> !o_system_clock_run && !o_periph_run && !o_cpu_run;
  endproperty
  a_suspend_clock: assert property (p_suspend_clock) else $error("clock on"); // [RULE4]

  property p_low_power_halt;
    o_mode[3:2] != 2'b00 |-> !o_cpu_run && !o_irq_timer_run && !o_internal_osc_run;
  endproperty
  a_low_power_halt: assert property (p_low_power_halt) else $error("not halted"); // [RULE5]

  property p_stop_hold;
    mode == power_mode_reset_pkg::MODE_STOP && !o_device_reset
      |=> mode == power_mode_reset_pkg::MODE_STOP && !o_system_clock_run;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left early"); // [RULE6]

  property p_reset_width;
    $rose(o_device_reset) |-> o_device_reset [*4] ##1 (mode == power_mode_reset_pkg::MODE_ACTIVE);
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset too short"); // [RULE7]

  property p_always_on;
    i_pin_reset || i_flash_error || i_power_on_detect |=> o_device_reset;
  endproperty
  a_always_on: assert property (p_always_on) else $error("source lost"); // [RULE8]

  property p_wdog_lock;
    wdog_lock |=> wdog_lock && o_watchdog_enable;
  endproperty
  a_wdog_lock: assert property (p_wdog_lock) else $error("watchdog unlocked"); // [RULE9]

  property p_debug_stall;
    i_debug_halt |=> !o_periph_run && (o_adc_run == o_system_clock_run);
  endproperty
  a_debug_stall: assert property (p_debug_stall) else $error("not stalled"); // [RULE10]

  c_idle_trip:    cover property (mode == power_mode_reset_pkg::MODE_IDLE ##[1:20]
                                  mode == power_mode_reset_pkg::MODE_ACTIVE);
  c_suspend_wake: cover property (mode == power_mode_reset_pkg::MODE_SUSPEND && wake);
  c_stop_reset:   cover property (mode == power_mode_reset_pkg::MODE_STOP && o_device_reset);
  c_debug_halt:   cover property (i_debug_halt && o_adc_run);

endmodule : power_mode_reset_control

`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [4:0]  i_address = 5'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0000_0000;
  logic [3:0]  i_byteenable = 4'hF;
  logic        i_irq_pending = 1'b0;
  logic        i_debug_halt = 1'b0;
  logic [2:0]  wake = 3'h0;
  logic [7:0]  src = 8'h00;
  logic [31:0] rd;
  logic [31:0] o_readdata;
  logic [3:0]  o_mode;
  logic        o_waitrequest, o_cpu_run, o_system_clock_run, o_periph_run, o_adc_run;
  logic        o_irq_timer_run, o_internal_osc_run, o_watchdog_enable, o_device_reset;
  wire  logic [5:0] run = {o_cpu_run, o_system_clock_run, o_periph_run, o_adc_run,
                           o_irq_timer_run, o_internal_osc_run};
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #50 i_clock = ~i_clock;
  // hold of 4 cycles, the same as the package default RESET_HOLD_CYCLES
  power_mode_reset_control #(.HOLD_CYCLES(4)) power_mode_reset_control_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_irq_pending(i_irq_pending),
    .i_port0_match(wake[0]), .i_port1_match(wake[1]), .i_comparator_enable(wake[2]),
    .i_comparator_out(~wake[2]), .i_debug_halt(i_debug_halt), .i_power_on_detect(src[0]),
    .i_vdd_low(src[1]), .i_watchdog_expired(src[2]), .i_missing_clock(src[3]),
    .i_comparator_reset(src[4]), .i_pin_reset(src[6]), .i_flash_error(src[7]),
    .o_cpu_run(o_cpu_run), .o_system_clock_run(o_system_clock_run),
    .o_periph_run(o_periph_run), .o_adc_run(o_adc_run), .o_irq_timer_run(o_irq_timer_run),
    .o_internal_osc_run(o_internal_osc_run), .o_watchdog_enable(o_watchdog_enable),
    .o_device_reset(o_device_reset), .o_mode(o_mode));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
  endtask : step
  // values read right after an edge are those sampled at it
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    i_read      <= ~wr;
    i_write     <= wr;
    i_address   <= a;
    i_writedata <= d;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read  <= 1'b0;
    i_write <= 1'b0;
    step(1);
  endtask : bus
  task automatic pulse(input int s);
    src <= 8'h01 << s;
    step(1);
    src <= 8'h00;
    step(2);
  endtask : pulse
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    step(10);
    i_rst_b <= 1'b1;
    step(3);
    chk("mode", 4'b0001, o_mode);
    chk("run", 6'b11_1111, run);
    bus(0, 5'h0C, 0); chk("cause", 8'h01, rd);
    bus(1, 5'h00, 32'h0000_0001); step(2);
    chk("idle mode", 4'b0010, o_mode);
    chk("idle run", 6'b01_1111, run);
    i_irq_pending <= 1'b1; step(3); i_irq_pending <= 1'b0;
    chk("idle exit", 4'b0001, o_mode);
    bus(0, 5'h00, 0); chk("idle bit", 0, rd);
    // write without the low byte lane must leave the mode alone
    i_byteenable <= 4'h0; bus(1, 5'h00, 32'h0000_0001); i_byteenable <= 4'hF;
    step(2); chk("no byte lane", 4'b0001, o_mode);
    for (int k = 0; k < 3; k++) begin
      bus(1, 5'h04, 32'h0000_0030); step(2);
      chk("suspend mode", 4'b0100, o_mode);
      chk("suspend run", 0, run);
      wake <= 3'h1 << k; step(3); wake <= 3'h0;
      chk("suspend exit", 4'b0001, o_mode);
      bus(0, 5'h04, 0); chk("osc reg", 32'h0000_0010, rd);
    end
    // suspend on an external clock keeps the system clock and peripherals going
    bus(1, 5'h04, 32'h0000_0020); step(2);
    chk("ext suspend run", 6'b01_1100, run);
    wake <= 3'h1; step(3); wake <= 3'h0;
    chk("ext suspend exit", 4'b0001, o_mode);
    bus(1, 5'h04, 32'h0000_0010);
    bus(1, 5'h00, 32'h0000_0002); i_irq_pending <= 1'b1; step(4); i_irq_pending <= 1'b0;
    chk("stop mode", 4'b1000, o_mode);
    chk("stop run", 0, run & 6'b11_1011);
    pulse(6); step(8);
    chk("stop exit", 4'b0001, o_mode);
    bus(0, 5'h00, 0); chk("stop bit", 0, rd);
    i_debug_halt <= 1'b1; step(3);
    chk("debug run", 2'b01, run[3:2]);
    i_debug_halt <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      if (s == 5) begin
        bus(1, 5'h10, 32'h0000_0001); step(1);
      end else begin
        pulse(s);
      end
      chk("reset out", 1, o_device_reset);
      step(8); bus(0, 5'h0C, 0); chk("cause", 8'h01 << s, rd);
    end
    bus(1, 5'h08, 0); bus(0, 5'h08, 0); chk("enables", 8'hC1, rd);
    for (int s = 1; s < 5; s++) begin
      pulse(s); chk("masked reset", 0, o_device_reset);
    end
    bus(1, 5'h18, 0); step(1); chk("wdog off", 0, o_watchdog_enable);
    bus(1, 5'h18, 32'h0000_0003); bus(1, 5'h18, 0); bus(0, 5'h18, 0);
    chk("wdog lock", 32'h0000_0003, rd);
    chk("wdog out", 1, o_watchdog_enable);
    bus(0, 5'h1C, 0); chk("unmapped", 0, rd);
    final_report();
  end
endmodule : testbench
`default_nettype wire
